//--- logic/smc_pkg.sv
// Shared constants and types of the sensor measurement control block
package smc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [11:0] IDX_STATUS_CTRL  = 12'h040;
	localparam logic [11:0] IDX_MEASURE_CTRL = 12'h041;
	localparam logic [11:0] IDX_IRQ_STATUS   = 12'h048;
	localparam logic [11:0] IDX_IRQ_MASK     = 12'h049;
	localparam logic [11:0] IDX_SETTLE       = 12'h04A;
	// Field positions in status/control
	localparam int unsigned BIT_ACQ_START    = 4;
	localparam int unsigned BIT_LOW_POWER    = 3;
	// Field positions in measure control
	localparam int unsigned BIT_DIRECT_ON    = 7;
	localparam int unsigned BIT_CAPTURE      = 6;
	localparam int unsigned BIT_CHAN_HI      = 5;
	localparam int unsigned BIT_CHAN_LO      = 4;
	localparam int unsigned BIT_PARITY       = 3;
	// Interrupt status bits
	localparam int unsigned IRQ_DONE         = 0;
	localparam int unsigned IRQ_TRIG         = 1;
	localparam int unsigned IRQ_PARITY       = 2;
	// Reset values
	localparam logic [7:0]  RST_CTRL         = 8'h00;
	localparam logic [7:0]  RST_MASK         = 8'h00;
	localparam logic [7:0]  RST_SETTLE       = 8'h00;
	// Bus answers
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;
	// Settle timing base: one medium oscillator period in core cycles
	localparam int unsigned CLK_PERIOD_NS    = 50;
	localparam int unsigned MFO_PERIOD_NS    = 8000;
	localparam int unsigned MFO_CYCLES       = MFO_PERIOD_NS / CLK_PERIOD_NS;
	// Multiplexer channels
	typedef enum logic [1:0] {
		CH_PRESSURE = 2'h0,
		CH_ACCEL_S  = 2'h1,
		CH_ACCEL_N  = 2'h2,
		CH_AUX      = 2'h3
	} smc_chan_t;
	// Sequencer states
	typedef enum logic [1:0] {
		FSM_IDLE   = 2'h0,
		FSM_SETTLE = 2'h1,
		FSM_CONV   = 2'h2,
		FSM_LP     = 2'h3
	} smc_fsm_t;
endpackage

//--- logic/smc_settle_if.sv
// Carrier between the sequencer and the settle timer
`timescale 1ns/1ns
interface smc_settle_if;
	logic       start;  // Load and run the timer
	logic [4:0] ticks;  // Delay in oscillator periods
	logic       done;   // One-cycle pulse at expiry
	modport ctl (output start, output ticks, input done);
	modport tmr (input start, input ticks, output done);
endinterface

//--- logic/smc_settle_timer.sv
// Settle delay timer counting medium oscillator periods
`timescale 1ns/1ns
module smc_settle_timer #(
	parameter int unsigned DIV = smc_pkg::MFO_CYCLES  // Core cycles per period
) (
	input  wire logic  core_clk_in,  // Core clock
	input  wire logic  reset_n_in,   // Async reset, low
	smc_settle_if.tmr  tmr_if        // Start and expiry
);
	localparam int unsigned PW = $clog2(DIV);

	// Whole timer state
	typedef struct packed {
		logic          run;   // Counting
		logic [PW-1:0] pre;   // Prescaler
		logic [4:0]    rem;   // Periods left
		logic          done;  // Expiry pulse
	} smc_tmr_t;

	smc_tmr_t st_ff;   // Registered state
	smc_tmr_t nxt_st;  // Next state

	// Countdown; a new start restarts the delay from the top
	always_comb begin
		nxt_st = st_ff;
		nxt_st.done = 1'b0;
		if (tmr_if.start) begin
			nxt_st.run = 1'b1;
			nxt_st.pre = PW'(DIV - 1);
			nxt_st.rem = tmr_if.ticks;
		end else if (st_ff.run) begin
			if (st_ff.pre != '0) begin
				nxt_st.pre = st_ff.pre - 1'b1;
			end else if (st_ff.rem <= 5'h01) begin
				// Last period elapsed
				nxt_st.run = 1'b0;
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.rem = st_ff.rem - 5'h01;
				nxt_st.pre = PW'(DIV - 1);
			end
		end
	end

	// State register
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tmr_if.done = st_ff.done;
endmodule

//--- logic/smc_top.sv
// Sensor measurement control with AXI4-Lite register slave
// Functional notes
// - Start bit launches auto acquisition, powers stage
// - Start bit reads 1 while measuring
// - Low-power bit picks direct-mode variant
// - Direct enable refused while start bit set
// - Capture clears when low-power bit falls
// - Direct enable reads 1 in direct modes
// - Capture writes ignored during auto acquisition
// - Plain direct capture gives one trigger
// - Low-power capture stays, triggers repeat
// - Two-bit channel select drives multiplexer
// - Parity fault sets sticky status bit
// - First wait initial delay, later shorter; here the later delay comes from settle[7:4] on its own and can be longer
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
module smc_top (
	input  wire logic        core_clk_in,        // Core clock, 20 MHz
	input  wire logic        reset_n_in,         // Async reset, low
	input  wire logic [11:0] s_axi_awaddr_in,    // Write address
	input  wire logic        s_axi_awvalid_in,   // Write address valid
	output logic             s_axi_awready_out,  // Write address ready
	input  wire logic [31:0] s_axi_wdata_in,     // Write data
	input  wire logic [3:0]  s_axi_wstrb_in,     // Byte enables
	input  wire logic        s_axi_wvalid_in,    // Write data valid
	output logic             s_axi_wready_out,   // Write data ready
	output logic [1:0]       s_axi_bresp_out,    // Write answer
	output logic             s_axi_bvalid_out,   // Write answer valid
	input  wire logic        s_axi_bready_in,    // Write answer ready
	input  wire logic [11:0] s_axi_araddr_in,    // Read address
	input  wire logic        s_axi_arvalid_in,   // Read address valid
	output logic             s_axi_arready_out,  // Read address ready
	output logic [31:0]      s_axi_rdata_out,    // Read data
	output logic [1:0]       s_axi_rresp_out,    // Read answer
	output logic             s_axi_rvalid_out,   // Read data valid
	input  wire logic        s_axi_rready_in,    // Read data ready
	input  wire logic        adc_done_in,        // Conversion finished
	input  wire logic        parity_err_in,      // Internal parity fault
	output logic             c2v_power_out,      // Stage power enable
	output logic [1:0]       chan_sel_out,       // Multiplexer channel
	output logic             adc_trig_out,       // Conversion trigger pulse
	output logic             halt_ok_out,        // Deep halt allowed
	output logic             irq_out             // Interrupt level
);
	// Whole block state
	typedef struct packed {
		logic                aw_hold;    // Write address taken
		logic [11:0]         aw_addr;    // Held write address
		logic                w_hold;     // Write data taken
		logic [7:0]          w_data;     // Held low byte
		logic                w_en;       // Low lane enabled
		logic                bvalid;     // Write answer pending
		logic [1:0]          bresp;      // Write answer code
		logic                rvalid;     // Read answer pending
		logic [7:0]          rdata;      // Read byte
		logic [1:0]          rresp;      // Read answer code
		logic                acq_start;  // Auto acquisition busy
		logic                low_power;  // Low-power direct variant
		logic                direct_on;  // Direct mode enabled
		logic                capture;    // Capture trigger bit
		smc_pkg::smc_chan_t  chan;       // Channel select
		logic                parity;     // Parity fault flag
		logic [7:0]          irq_stat;   // Sticky event bits
		logic [7:0]          irq_mask;   // Event mask
		logic [7:0]          settle;     // Later/initial delay fields
		smc_pkg::smc_fsm_t   fsm;        // Sequencer state
		logic                adc_trig;   // Trigger pulse
	} smc_regs_t;

	smc_regs_t    st_ff;     // Registered state
	smc_regs_t    nxt_st;    // Next state
	smc_settle_if tmr_bus(); // Settle timer link

	logic         wr_fire;   // Write carried out this cycle
	logic         wr_st;     // Write to status/control
	logic         wr_ctl;    // Write to measure control
	logic [7:0]   wd;        // Byte being written
	logic         rd_fire;   // Read taken this cycle
	logic         lp_run;    // Low-power repeat allowed
	logic [4:0]   isd_ticks; // Initial delay periods
	logic [4:0]   sp_ticks;  // Later delay periods

	// Register index from a byte address
	function automatic logic [11:0] reg_idx(input logic [11:0] a);
		reg_idx = {2'h0, a[11:2]};
	endfunction

	smc_settle_timer u_timer (
		.core_clk_in (core_clk_in),
		.reset_n_in  (reset_n_in),
		.tmr_if      (tmr_bus.tmr)
	);

	// Bus decode shared by logic and checks
	assign wr_fire = st_ff.aw_hold && st_ff.w_hold && !st_ff.bvalid;
	assign wd = st_ff.w_en ? st_ff.w_data : 8'h00;
	assign wr_st = wr_fire && st_ff.w_en && reg_idx(st_ff.aw_addr) == smc_pkg::IDX_STATUS_CTRL;
	assign wr_ctl = wr_fire && st_ff.w_en && reg_idx(st_ff.aw_addr) == smc_pkg::IDX_MEASURE_CTRL;
	assign rd_fire = s_axi_arvalid_in && !st_ff.rvalid;
	assign lp_run = st_ff.low_power && st_ff.direct_on && st_ff.capture;
	assign isd_ticks = {1'b0, st_ff.settle[3:0]} + 5'h01;
	assign sp_ticks = {1'b0, st_ff.settle[7:4]} + 5'h01;

	// Next-state logic: bus, register effects, sequencer, events
	always_comb begin
		logic [7:0] rd;   // Read mux
		logic       hit;  // Read address mapped
		logic [7:0] ev;   // Events this cycle
		rd = 8'h00;
		hit = 1'b1;
		ev = 8'h00;
		nxt_st = st_ff;
		nxt_st.adc_trig = 1'b0;
		tmr_bus.start = 1'b0;
		tmr_bus.ticks = isd_ticks;

		// Channel capture; either order of address and data
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			nxt_st.aw_hold = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			nxt_st.w_hold = 1'b1;
			nxt_st.w_data = s_axi_wdata_in[7:0];
			nxt_st.w_en = s_axi_wstrb_in[0];
		end
		if (st_ff.bvalid && s_axi_bready_in) begin
			nxt_st.bvalid = 1'b0;
		end

		// Plain direct capture self-clears; with direct off it just drops
		if (st_ff.capture && !st_ff.low_power) begin
			nxt_st.adc_trig = st_ff.direct_on;
			nxt_st.capture = 1'b0;
		end

		// Register write once both halves are held
		if (wr_fire) begin
			nxt_st.aw_hold = 1'b0;
			nxt_st.w_hold = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = smc_pkg::RESP_OKAY;
			unique case (reg_idx(st_ff.aw_addr))
				smc_pkg::IDX_STATUS_CTRL: begin
					if (wd[smc_pkg::BIT_ACQ_START] && st_ff.fsm == smc_pkg::FSM_IDLE &&
						!st_ff.acq_start && !st_ff.direct_on) begin
						nxt_st.acq_start = 1'b1;
					end
					nxt_st.low_power = st_ff.w_en ? wd[smc_pkg::BIT_LOW_POWER] : st_ff.low_power;
				end
				smc_pkg::IDX_MEASURE_CTRL: begin
					if (st_ff.w_en) begin
						if (!wd[smc_pkg::BIT_DIRECT_ON]) begin
							nxt_st.direct_on = 1'b0;
						end else if (!st_ff.acq_start) begin
							nxt_st.direct_on = 1'b1;
						end
						if (wd[smc_pkg::BIT_CAPTURE] && !st_ff.acq_start) begin
							nxt_st.capture = 1'b1;
						end
						nxt_st.chan = smc_pkg::smc_chan_t'(wd[smc_pkg::BIT_CHAN_HI:smc_pkg::BIT_CHAN_LO]);
						// Write one clears the fault flag
						if (wd[smc_pkg::BIT_PARITY]) begin
							nxt_st.parity = 1'b0;
						end
					end
				end
				smc_pkg::IDX_IRQ_MASK: begin
					nxt_st.irq_mask = st_ff.w_en ? wd : st_ff.irq_mask;
				end
				smc_pkg::IDX_SETTLE: begin
					nxt_st.settle = st_ff.w_en ? wd : st_ff.settle;
				end
				smc_pkg::IDX_IRQ_STATUS: begin
					// Read-only; write is accepted and has no effect
				end
				default: begin
					nxt_st.bresp = smc_pkg::RESP_SLVERR;
				end
			endcase
		end

		if (st_ff.low_power && !nxt_st.low_power) begin
			nxt_st.capture = 1'b0;
		end

		// Sequencer
		unique case (st_ff.fsm)
			smc_pkg::FSM_IDLE: begin
				if (st_ff.acq_start) begin
					tmr_bus.start = 1'b1;
					nxt_st.fsm = smc_pkg::FSM_SETTLE;
				end else if (lp_run) begin
					tmr_bus.start = 1'b1;
					nxt_st.fsm = smc_pkg::FSM_LP;
				end
			end
			smc_pkg::FSM_SETTLE: begin
				if (tmr_bus.done) begin
					nxt_st.adc_trig = 1'b1;
					nxt_st.fsm = smc_pkg::FSM_CONV;
				end
			end
			smc_pkg::FSM_CONV: begin
				if (adc_done_in) begin
					nxt_st.acq_start = 1'b0;
					ev[smc_pkg::IRQ_DONE] = 1'b1;
					nxt_st.fsm = smc_pkg::FSM_IDLE;
				end
			end
			smc_pkg::FSM_LP: begin
				if (!lp_run) begin
					// Exit returns to idle so re-entry sees initial delay
					nxt_st.fsm = smc_pkg::FSM_IDLE;
				end else if (tmr_bus.done) begin
					nxt_st.adc_trig = 1'b1;
					tmr_bus.start = 1'b1;
					tmr_bus.ticks = sp_ticks;
				end
			end
		endcase

		if (parity_err_in) begin
			nxt_st.parity = 1'b1;
			ev[smc_pkg::IRQ_PARITY] = 1'b1;
		end
		ev[smc_pkg::IRQ_TRIG] = nxt_st.adc_trig;

		// Read mux; only mapped fields are filled
		// reserved bits zero
		unique case (reg_idx(s_axi_araddr_in))
			smc_pkg::IDX_STATUS_CTRL: begin
				rd[smc_pkg::BIT_ACQ_START] = st_ff.acq_start;
				rd[smc_pkg::BIT_LOW_POWER] = st_ff.low_power;
			end
			smc_pkg::IDX_MEASURE_CTRL: begin
				rd[smc_pkg::BIT_DIRECT_ON] = st_ff.direct_on;
				rd[smc_pkg::BIT_CAPTURE] = st_ff.capture;
				rd[smc_pkg::BIT_CHAN_HI:smc_pkg::BIT_CHAN_LO] = st_ff.chan;
				rd[smc_pkg::BIT_PARITY] = st_ff.parity;
			end
			smc_pkg::IDX_IRQ_STATUS: rd = st_ff.irq_stat;
			smc_pkg::IDX_IRQ_MASK:   rd = st_ff.irq_mask;
			smc_pkg::IDX_SETTLE:     rd = st_ff.settle;
			default:                 hit = 1'b0;
		endcase

		// Sticky events; an interrupt status read clears, a same-cycle event survives
		nxt_st.irq_stat = st_ff.irq_stat | ev;
		if (rd_fire) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata = rd;
			nxt_st.rresp = hit ? smc_pkg::RESP_OKAY : smc_pkg::RESP_SLVERR;
			if (reg_idx(s_axi_araddr_in) == smc_pkg::IDX_IRQ_STATUS) begin
				nxt_st.irq_stat = ev;
			end
		end else if (st_ff.rvalid && s_axi_rready_in) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// State register; every field has a constant reset value
	always_ff @(posedge core_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			st_ff <= '0;
			st_ff.irq_mask <= smc_pkg::RST_MASK;
			st_ff.settle <= smc_pkg::RST_SETTLE;
			st_ff.fsm <= smc_pkg::FSM_IDLE;
			st_ff.chan <= smc_pkg::CH_PRESSURE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Ready terms stall a new transfer until the answer is gone
	assign s_axi_awready_out = !st_ff.aw_hold && !st_ff.bvalid;
	assign s_axi_wready_out = !st_ff.w_hold && !st_ff.bvalid;
	assign s_axi_arready_out = !st_ff.rvalid;
	assign s_axi_bvalid_out = st_ff.bvalid;
	assign s_axi_bresp_out = st_ff.bresp;
	assign s_axi_rvalid_out = st_ff.rvalid;
	assign s_axi_rdata_out = {24'h000000, st_ff.rdata};
	assign s_axi_rresp_out = st_ff.rresp;
	assign c2v_power_out = st_ff.acq_start || st_ff.direct_on;
	assign chan_sel_out = st_ff.chan;
	assign adc_trig_out = st_ff.adc_trig;
	assign halt_ok_out = st_ff.low_power;
	assign irq_out = |(st_ff.irq_stat & st_ff.irq_mask);

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);

	AST_START_POWER: assert property (
		(wr_st && wd[smc_pkg::BIT_ACQ_START] && st_ff.fsm == smc_pkg::FSM_IDLE && !st_ff.acq_start &&
		!st_ff.direct_on) |=> (st_ff.acq_start && c2v_power_out) ##1 st_ff.fsm == smc_pkg::FSM_SETTLE)
		else $error("start write did not launch acquisition");
	AST_DONE_CLEARS: assert property (
		(st_ff.fsm == smc_pkg::FSM_CONV && adc_done_in) |=> !st_ff.acq_start && st_ff.irq_stat[0])
		else $error("start bit stayed set after completion");
	AST_VARIANT: assert property (
		wr_st |=> st_ff.low_power == $past(wd[smc_pkg::BIT_LOW_POWER]))
		else $error("low-power bit not written");
	AST_REFUSE: assert property (
		(wr_ctl && wd[smc_pkg::BIT_DIRECT_ON] && st_ff.acq_start && !st_ff.direct_on) |=> !st_ff.direct_on)
		else $error("direct enable set during auto acquisition");
	AST_LP_FALL: assert property (
		$fell(st_ff.low_power) |-> !st_ff.capture)
		else $error("capture survived low-power exit");
	AST_IGNORE_CAP: assert property (
		(wr_ctl && st_ff.acq_start && !st_ff.capture) |=> !st_ff.capture)
		else $error("capture taken during auto acquisition");
	AST_ONE_TRIG: assert property (
		(st_ff.capture && st_ff.direct_on && !st_ff.low_power) |=> adc_trig_out)
		else $error("direct capture gave no trigger");
	AST_LP_HOLD: assert property (
		(st_ff.capture && st_ff.low_power) |=> st_ff.capture || !st_ff.low_power)
		else $error("capture cleared while low-power held");
	AST_CHAN: assert property (
		wr_ctl |=> chan_sel_out == $past(wd[5:4]))
		else $error("channel select not applied");
	AST_PARITY: assert property (
		parity_err_in |=> st_ff.parity ##0 st_ff.irq_stat[2])
		else $error("parity fault not flagged");
	AST_RESERVED: assert property (
		(rd_fire && reg_idx(s_axi_araddr_in) == smc_pkg::IDX_MEASURE_CTRL) |=> s_axi_rdata_out[2:0] == 3'h0)
		else $error("reserved bits read nonzero");

	COV_AUTO: cover property (st_ff.fsm == smc_pkg::FSM_CONV ##[1:50] !st_ff.acq_start);
	COV_LP_TWO: cover property (st_ff.fsm == smc_pkg::FSM_LP && adc_trig_out ##[1:1000] adc_trig_out);
	COV_DIRECT: cover property (st_ff.direct_on && !st_ff.low_power && adc_trig_out);
	COV_IRQ: cover property (irq_out ##1 rd_fire);
endmodule

//--- testbench/smc_adc_model.sv
// Behavioural converter model answering conversion triggers
`timescale 1ns/1ns
module smc_adc_model (
	input  wire logic clk_in,    // Core clock
	input  wire logic rst_n_in,  // Async reset, low
	input  wire logic trig_in,   // Conversion trigger pulse
	input  wire logic slow_in,   // Long conversion when high
	output logic      done_out   // One-cycle finish pulse
);
	int cnt;  // Cycles left in the running conversion
	// Conversion timer; a new trigger restarts it, as a real converter would
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt <= 0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (trig_in)
				cnt <= slow_in ? 20 : 2;
			else if (cnt == 1) begin
				done_out <= 1'b1;
				cnt <= 0;
			end else if (cnt > 1)
				cnt <= cnt - 1;
		end
	end
endmodule

//--- testbench/smc_top_tb.sv
// Self-checking bench for the measurement control block
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module smc_top_tb;
	logic        clk = 0, rst_n = 0;           // Clock and reset
	logic [11:0] awaddr = 0, araddr = 0;       // Bus addresses
	logic        awvalid = 0, wvalid = 0;      // Write valids
	logic        bready = 0, arvalid = 0;      // Handshakes
	logic        rready = 0, par_err = 0;      // Read ready, fault
	logic        slow = 0;                     // Converter speed
	logic [31:0] wdata = 0;                    // Write data
	logic [3:0]  wstrb = 0;                    // Byte enables
	logic [3:0]  strb = 4'hF;                  // Strobe the next write uses
	logic        awready, wready, bvalid, arready, rvalid, done;
	logic        c2v, trig, halt, irq;
	logic [1:0]  bresp, rresp, chan;
	logic [31:0] rdata;
	int          miscompares = 0, checked = 0; // Report counters
	int          cyc = 0, trig_cnt = 0;        // Cycle and trigger counts
	int          trig_t[16];                   // Trigger times
	int          t0;
	logic [7:0]  d;
	logic [1:0]  r;
	always #25 clk = ~clk;
	smc_top DUT (.core_clk_in(clk), .reset_n_in(rst_n), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .adc_done_in(done), .parity_err_in(par_err),
		.c2v_power_out(c2v), .chan_sel_out(chan), .adc_trig_out(trig),
		.halt_ok_out(halt), .irq_out(irq));
	smc_adc_model ADC (.clk_in(clk), .rst_n_in(rst_n), .trig_in(trig), .slow_in(slow), .done_out(done));
	// Log trigger pulses so spacing can be checked afterwards
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rst_n && trig === 1'b1) begin
			if (trig_cnt < 16)
				trig_t[trig_cnt] <= cyc;
			trig_cnt <= trig_cnt + 1;
		end
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Write one byte; handshakes judged at the falling edge, where they are settled
	task automatic wr(input logic [11:0] idx, input logic [7:0] v, input logic [1:0] er);
		int n;
		logic ha, hw, hb;
		n = 0;
		@(posedge clk);
		awaddr <= {idx[9:0], 2'h0};
		wdata <= {24'h0, v};
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid;
			r = bresp;
			@(posedge clk);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			n++;
		end while (hb !== 1'b1 && n < 1000);
		bready <= 1'b0;
		if (n >= 1000) begin
			miscompares++;
			$display("[ERR] %0t write timeout", $time);
		end
		`CHK(r, er)
	endtask
	// Read one byte; address held until taken, rready until data seen
	task automatic rd(input logic [11:0] idx);
		int n;
		logic ha, hr;
		n = 0;
		@(posedge clk);
		araddr <= {idx[9:0], 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ha = arvalid && arready;
			hr = rvalid;
			d = rdata[7:0];
			r = rresp;
			@(posedge clk);
			if (ha) arvalid <= 1'b0;
			n++;
		end while (hr !== 1'b1 && n < 1000);
		rready <= 1'b0;
		if (n >= 1000) begin
			miscompares++;
			$display("[ERR] %0t read timeout", $time);
		end
	endtask
	task automatic chk(input logic [11:0] idx, input logic [7:0] e);
		rd(idx);
		`CHK(d, e)
		`CHK(r, smc_pkg::RESP_OKAY)
	endtask
	// Poll until a bit of a register reads zero, bounded
	task automatic poll(input logic [11:0] idx, input int b);
		int n;
		n = 0;
		do begin
			rd(idx);
			n++;
		end while (d[b] !== 1'b0 && n < 200);
		`CHK(d[b], 1'b0)
	endtask
	task automatic wait_trig(input int k);
		int n;
		n = 0;
		while (trig_cnt < k && n < 3000) begin
			@(posedge clk);
			n++;
		end
		`CHK(trig_cnt >= k, 1'b1)
	endtask
	// Hang guard, well beyond the under two thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		$display("[ERR] %0t watchdog expired", $time);
		complete_run;
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values and unmapped place
		chk(smc_pkg::IDX_STATUS_CTRL, 8'h00);
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'h00);
		chk(smc_pkg::IDX_IRQ_MASK, 8'h00);
		`CHK({c2v, chan, halt, irq}, 5'h00)
		rd(12'h3F0);
		`CHK({r, d}, {smc_pkg::RESP_SLVERR, 8'h00})
		wr(12'h3F0, 8'hFF, smc_pkg::RESP_SLVERR);
		// Write without the low byte lane must change nothing
		strb = 4'hE;
		wr(smc_pkg::IDX_STATUS_CTRL, 8'h18, smc_pkg::RESP_OKAY);
		strb = 4'hF;
		chk(smc_pkg::IDX_STATUS_CTRL, 8'h00);
		`CHK({c2v, halt}, 2'b00)
		$display("test reset done");
		// Every channel code, reserved bits written high
		for (int c = 0; c < 4; c++) begin
			wr(smc_pkg::IDX_MEASURE_CTRL, {2'h0, 2'(c), 4'hF}, smc_pkg::RESP_OKAY);
			chk(smc_pkg::IDX_MEASURE_CTRL, {2'h0, 2'(c), 4'h0});
			`CHK(chan, 2'(c))
		end
		$display("test channels done");
		// Auto acquisition with slow converter, writes during it
		slow <= 1'b1;
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h00, smc_pkg::RESP_OKAY);
		wr(smc_pkg::IDX_SETTLE, 8'h10, smc_pkg::RESP_OKAY);
		wr(smc_pkg::IDX_IRQ_MASK, 8'h01, smc_pkg::RESP_OKAY);
		wr(smc_pkg::IDX_STATUS_CTRL, 8'h10, smc_pkg::RESP_OKAY);
		chk(smc_pkg::IDX_STATUS_CTRL, 8'h10);
		`CHK(c2v, 1'b1)
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h80, smc_pkg::RESP_OKAY);
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'h00);
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h40, smc_pkg::RESP_OKAY);
		poll(smc_pkg::IDX_STATUS_CTRL, 4);
		`CHK(trig_cnt, 1)
		`CHK({irq, c2v}, 2'b10)
		chk(smc_pkg::IDX_IRQ_STATUS, 8'h03);
		`CHK(irq, 1'b0)
		$display("test auto done");
		// Plain direct mode, single trigger per capture write
		slow <= 1'b0;
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h80, smc_pkg::RESP_OKAY);
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'h80);
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'hE0, smc_pkg::RESP_OKAY);
		wait_trig(2);
		repeat (20) @(posedge clk);
		`CHK(trig_cnt, 2)
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'hA0);
		`CHK(chan, smc_pkg::CH_ACCEL_N)
		poll(smc_pkg::IDX_MEASURE_CTRL, 6);
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h00, smc_pkg::RESP_OKAY);
		`CHK(c2v, 1'b0)
		$display("test direct done");
		// Low-power entry, repeating triggers, then exit
		wr(smc_pkg::IDX_STATUS_CTRL, 8'h08, smc_pkg::RESP_OKAY);
		`CHK(halt, 1'b1)
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h80, smc_pkg::RESP_OKAY);
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'hC0, smc_pkg::RESP_OKAY);
		t0 = cyc;
		wait_trig(5);
		`CHK((trig_t[2] - t0) inside {[150:170]}, 1'b1)
		`CHK((trig_t[3] - trig_t[2]) inside {[320:326]}, 1'b1)
		`CHK((trig_t[4] - trig_t[3]) inside {[320:326]}, 1'b1)
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'hC0);
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h40, smc_pkg::RESP_OKAY);
		wr(smc_pkg::IDX_STATUS_CTRL, 8'h00, smc_pkg::RESP_OKAY);
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'h00);
		t0 = trig_cnt;
		repeat (400) @(posedge clk);
		`CHK({trig_cnt == t0, halt}, 2'b10)
		$display("test low power done");
		// Parity fault: sticky flag, masked then unmasked interrupt, clear
		rd(smc_pkg::IDX_IRQ_STATUS);
		wr(smc_pkg::IDX_IRQ_MASK, 8'h00, smc_pkg::RESP_OKAY);
		par_err <= 1'b1;
		@(posedge clk);
		par_err <= 1'b0;
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'h08);
		`CHK(irq, 1'b0)
		wr(smc_pkg::IDX_IRQ_MASK, 8'h04, smc_pkg::RESP_OKAY);
		`CHK(irq, 1'b1)
		chk(smc_pkg::IDX_IRQ_STATUS, 8'h04);
		`CHK(irq, 1'b0)
		wr(smc_pkg::IDX_MEASURE_CTRL, 8'h08, smc_pkg::RESP_OKAY);
		chk(smc_pkg::IDX_MEASURE_CTRL, 8'h00);
		$display("test parity done");
		complete_run;
	end
endmodule
